// *** bus_side_model.sv ***
// bus_side_model: memory and one level-7 interrupting device
// assumes: word at a reads {a[7:0],8'h0C}; raise7 asks for one interrupt
`timescale 1ns/1ps
`default_nettype none
module bus_side_model
   import tail_seq_pkg::*;
(
   input  wire logic        pclk,
   input  wire mem_req_t    mem_out,
   output var  logic        mem_done,
   output var  logic [15:0] mem_rdata,
   input  wire logic [3:0]  bus_grant,
   input  wire logic        raise7,
   output var  logic [3:0]  bus_req,
   output var  logic        bus_intr,
   output var  logic [15:0] bus_data
);
   logic [15:0] rd_q[$];
   logic [15:0] wa_q[$];
   logic [15:0] wd_q[$];
   int          wait_n = 0;
   logic        g_q = 1'b0;
   logic        seen = 1'b0;
   // ==========================================
   // memory answers after wait_n cycles, done held until req drops
   initial begin
      mem_done = 1'b0;
      mem_rdata = 16'h0000;
      forever begin
         @(posedge pclk);
         if (mem_out.req === 1'b1) begin
            repeat (wait_n) @(posedge pclk);
            if (mem_out.write === 1'b1) begin
               wa_q.push_back(mem_out.addr);
               wd_q.push_back(mem_out.wdata);
            end
            else begin
               rd_q.push_back(mem_out.addr);
            end
            mem_rdata <= {mem_out.addr[7:0], 8'h0C};
            mem_done <= 1'b1;
            while (mem_out.req === 1'b1) @(posedge pclk);
            mem_done <= 1'b0;
            mem_rdata <= ~mem_rdata;
         end
      end
   end
   // ==========================================
   // device holds request and vector until its grant falls
   assign bus_req = {(raise7 && !seen) || bus_grant[3] === 1'b1, 3'b000};
   assign bus_intr = bus_req[3];
   assign bus_data = bus_req[3] ? 16'h0080 : 16'hFF7F;
   always @(posedge pclk) begin
      g_q <= bus_grant[3];
      seen <= raise7 && (seen || (g_q && !bus_grant[3]));
   end
endmodule : bus_side_model
`default_nettype wire

// *** microcoded_service_and_trap_sequencer_test.sv ***
// microcoded_service_and_trap_sequencer_test: self-checking bench of tail_seq
// assumes: bus_side_model stands on the memory and request pins
`timescale 1ns/1ps
`default_nettype none
module microcoded_service_and_trap_sequencer_test
   import tail_seq_pkg::*;
;
   typedef struct {logic [15:0] ir, idx, rn, s10, addr; int wt, nwr;} row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [5:0]  int_src = 6'h00;
   logic        raise7 = 1'b0;
   logic [31:0] prdata, rdv, ev;
   logic        pready, pslverr, irq, clock_inhibit, odd_byte_allow, halted, errv;
   logic        mem_done, bus_intr;
   logic        ob, ci;
   logic [3:0]  bg;
   logic [15:0] mem_rdata, bus_data;
   logic [3:0]  bus_req, bus_grant;
   mem_req_t    mem_out;
   int          n_fail = 0;
   int          n_tests = 0;
   row_t        rows[5] = '{
      '{16'h6001, 16'h0010, 16'h0100, 16'h0003, 16'h0110, 0, 1},
      '{16'h2002, 16'hFFFE, 16'h0040, 16'h0005, 16'h003E, 4, 0},
      '{16'h5003, 16'h0002, 16'h0020, 16'h0300, 16'h0022, 2, 1},
      '{16'h0041, 16'h0004, 16'h0010, 16'h0000, 16'h0014, 1, 0},
      '{16'hA005, 16'h0001, 16'h0040, 16'h0000, 16'h0041, 3, 0}};
   always #5 pclk = ~pclk;
   tail_seq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .mem_out(mem_out), .mem_done(mem_done),
      .mem_rdata(mem_rdata), .bus_req(bus_req), .bus_intr(bus_intr), .bus_data(bus_data),
      .bus_grant(bus_grant), .int_src(int_src), .clock_inhibit(clock_inhibit),
      .odd_byte_allow(odd_byte_allow), .halted(halted));
   bus_side_model m (.pclk(pclk), .mem_out(mem_out), .mem_done(mem_done),
      .mem_rdata(mem_rdata), .bus_grant(bus_grant), .raise7(raise7), .bus_req(bus_req),
      .bus_intr(bus_intr), .bus_data(bus_data));
   // ==========================================
   // report, compare and bus tasks
   task automatic tally_and_finish;
      if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_fail++;
         tally_and_finish();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic run(input logic [15:0] ir);
      int k;
      apb(1'b1, OFF_IR, {16'h0000, ir});
      m.rd_q.delete();
      m.wa_q.delete();
      m.wd_q.delete();
      apb(1'b1, OFF_CTRL, 32'h1);
      ob = 1'b0;
      ci = 1'b0;
      bg = 4'h0;
      k = 0;
      while (irq !== 1'b1 && k < 600) begin
         @(posedge pclk);
         k++;
         if (odd_byte_allow === 1'b1) ob = 1'b1;
         if (clock_inhibit === 1'b1) ci = 1'b1;
         bg = bg | bus_grant;
         foreach (m.rd_q[i]) if (m.rd_q[i] === VEC_POWER) int_src <= 6'h00;
      end
      if (k >= 600) begin
         n_fail++;
         tally_and_finish();
      end
      apb(1'b0, OFF_INT_STAT, 32'h0);
      ev = rdv;
   endtask : run
   // ==========================================
   // main sequence
   initial begin
      logic [15:0] d;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, OFF_INT_MASK, 32'h1);
      apb(1'b1, OFF_GPR + 8'h18, 32'h0200);
      foreach (rows[i]) begin
         m.wait_n = rows[i].wt;
         apb(1'b1, OFF_GPR + {3'h0, rows[i].ir[2:0], 2'h0}, {16'h0000, rows[i].rn});
         apb(1'b1, OFF_OPND, {16'h0000, rows[i].idx});
         apb(1'b1, OFF_SCR10, {16'h0000, rows[i].s10});
         run(rows[i].ir);
         d = {rows[i].addr[7:0], 8'h0C};
         chk("read addr", rows[i].addr, m.rd_q[0]);
         chk("writes", rows[i].nwr, m.wa_q.size());
         if (rows[i].nwr == 1) begin
            chk("wdata", rows[i].ir[13] ? rows[i].s10 + d : rows[i].s10 | d, m.wd_q[0]);
         end
         chk("events", 32'h1, ev);
         chk("odd allow", 32'h1, ob);
         chk("inhibit", 32'h1, ci);
      end
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, irq);
      apb(1'b0, OFF_INT_MASK, 32'h0);
      chk("mask", 32'h1, rdv);
      apb(1'b0, 8'h80, 32'h0);
      chk("slverr", 32'h1, errv);
      apb(1'b1, OFF_GPR + 8'h18, 32'h0200);
      int_src <= 6'h02;
      raise7 <= 1'b1;
      repeat (4) @(posedge pclk);
      run(16'h2001);
      raise7 <= 1'b0;
      chk("first vector", VEC_POWER, m.rd_q[1]);
      chk("second vector", 32'h80, m.rd_q[3]);
      foreach (m.wa_q[i]) chk("push addr", 32'h1FE - 2 * i, m.wa_q[i]);
      chk("pushes", 32'h4, m.wa_q.size());
      chk("events", 32'hD, ev);
      chk("grant", 32'h8, bg);
      apb(1'b0, OFF_SCR12, 32'h0);
      chk("scr12", 32'h80, rdv);
      apb(1'b0, OFF_GPR + 8'h1C, 32'h0);
      chk("pc", 32'h800C, rdv);
      apb(1'b1, OFF_PSW, 32'h10);
      run(16'h2001);
      chk("trace vector", VEC_TRACE, m.rd_q[1]);
      apb(1'b0, OFF_GPR + 8'h1C, 32'h0);
      chk("pc", 32'h100C, rdv);
      apb(1'b1, OFF_OPND, 32'h11);
      run(16'h6001);
      chk("berr vector", VEC_BERR, m.rd_q[1]);
      chk("berr events", 32'h3, ev);
      chk("berr pushes", 32'h2, m.wa_q.size());
      int_src <= 6'h20;
      repeat (4) @(posedge pclk);
      run(16'h2001);
      int_src <= 6'h00;
      chk("halted", 32'h1, halted);
      tally_and_finish();
   end
endmodule : microcoded_service_and_trap_sequencer_test
`default_nettype wire

// *** tail_seq.sv ***
// tail_seq: destination fetch, branch tests, service arbitration, trap entry
// assumes: APB master on pclk; memory, requests and vector lines are async pins
//
// How it works
// - indexed address is index word plus register picked by instruction bits 2:0, then read
// - odd-byte permission makes an odd address read legal
// - jump or subroutine decode diverts the indexed step, else operand receive
// - clock inhibit holds the sequence until the started read completes
// - byte operation at odd address moves the byte into the low half
// - after storing scratch 11, single-operand instructions take their own path
// - scratch 10 combined with operand by decoded function; condition codes set
// - non-modifying instructions go to service check; others write back first
// - eleven pending conditions arbitrated in fixed priority at instruction end
// - nothing pending means continue to fetch of next instruction
// - bus requests arbitrated only at service check; winner enters bus grant, left again if its request drops
// - bus grant tests for interrupt and loads vector from data lines to scratch 12
// - trap entry pushes status and counter, loads both from vector words
// - after trap entry another service check is made
// - internal traps take a fixed vector from the constants table
// - bus error overrides next step, abandons instruction, takes constant vector
// - without permission an odd address word transfer is a bus error
`timescale 1ns/1ps
`default_nettype none
module tail_seq
   import tail_seq_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic        irq,
   output var  mem_req_t    mem_out,
   input  wire logic        mem_done,
   input  wire logic [15:0] mem_rdata,
   input  wire logic [3:0]  bus_req,
   input  wire logic        bus_intr,
   input  wire logic [15:0] bus_data,
   output var  logic [3:0]  bus_grant,
   input  wire logic [5:0]  int_src,
   output var  logic        clock_inhibit,
   output var  logic        odd_byte_allow,
   output var  logic        halted
);
   // int_src: 0 stack overflow, 1 power fail, 2 line clock, 3 rx, 4 tx, 5 stop
   typedef enum logic [4:0] {
      S_IDLE = 5'h00, S_IDX  = 5'h01, S_DRX  = 5'h02, S_BYTE = 5'h03,
      S_STOR = 5'h04, S_UNRY = 5'h05, S_ALU  = 5'h06, S_WB1  = 5'h07,
      S_WB2  = 5'h08, S_SVC  = 5'h09, S_BG   = 5'h0A, S_INT  = 5'h0B,
      S_TRAP = 5'h0C, S_PSHS = 5'h0D, S_PSHP = 5'h0E, S_VPC  = 5'h0F,
      S_VPSW = 5'h10, S_BERR = 5'h11, S_HALT = 5'h12, S_JMP  = 5'h13,
      S_FTCH = 5'h14
   } state_t;

   // ==========================================
   // functions
   function automatic winner_t arbitrate(input logic [11:0] p);
      winner_t w;
      w = W_NEXT;
      for (int i = 10; i >= 0; i--) begin
         if (p[i]) begin
            w = winner_t'(4'(i));
         end
      end
      return w;
   endfunction : arbitrate

   function automatic logic [15:0] vec_of(input winner_t w);
      unique case (w)
         W_TRACE: return VEC_TRACE;
         W_STACK: return VEC_STACK;
         W_POWER: return VEC_POWER;
         W_LCLK:  return VEC_LCLK;
         W_URX:   return VEC_URX;
         default: return VEC_UTX;
      endcase
   endfunction : vec_of

   function automatic logic [16:0] alu(input logic [2:0] op, input logic [15:0] a,
                                       input logic [15:0] b);
      unique case (op)
         3'h1:    return {1'b0, a};
         3'h2:    return {1'b0, a} - {1'b0, b};
         3'h3:    return {1'b0, a & b};
         3'h4:    return {1'b0, ~a & b};
         3'h5:    return {1'b0, a | b};
         default: return {1'b0, a} + {1'b0, b};
      endcase
   endfunction : alu

   // ==========================================
   // pin synchronisers
   localparam int SW = 1 + 16 + 4 + 1 + 16 + 6;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {mem_done, mem_rdata, bus_req, bus_intr, bus_data, int_src};
         sync2_q <= sync1_q;
      end
   end
   logic        done_s;
   logic [15:0] rdata_s;
   logic [3:0]  br_s;
   logic        intr_s;
   logic [15:0] bdata_s;
   logic [5:0]  src_s;
   assign {done_s, rdata_s, br_s, intr_s, bdata_s, src_s} = sync2_q;

   // ==========================================
   // state
   state_t      st_q;
   logic        acc_q;
   logic [15:0] ir_q;
   logic [15:0] opnd_q;
   logic [15:0] ba_q;
   logic [15:0] scr10_q;
   logic [15:0] scr11_q;
   logic [15:0] scr12_q;
   logic [15:0] psw_q;
   logic [15:0] gpr_q [8];
   winner_t     win_q;
   logic [3:0]  ev_set;
   logic [3:0]  istat_q;
   logic [3:0]  imask_q;

   logic is_byte;
   logic is_jmp;
   logic is_jsr;
   logic is_unary;
   logic no_write;
   logic [11:0] pend;
   winner_t     win;
   assign is_byte  = ir_q[15];
   assign is_jmp   = ir_q[15:6] == 10'h001;
   assign is_jsr   = ir_q[15:9] == 7'h04;
   assign is_unary = ir_q[14:12] == 3'h0;
   assign no_write = (ir_q[14:12] == 3'h2) || (ir_q[14:12] == 3'h3)
                     || (is_unary && ir_q[8:6] == 3'h7);
   assign pend = {1'b0, src_s[5], src_s[4], src_s[3], br_s[0], br_s[1], src_s[2],
                  br_s[2], br_s[3], src_s[1], src_s[0], psw_q[PSW_TRACE]};
   assign win = arbitrate(pend);

   logic        apb_wr;
   logic        apb_rd;
   assign apb_wr = psel && penable && pready && pwrite;
   assign apb_rd = psel && penable && pready && !pwrite;

   // ==========================================
   // bus access helper: start, or finish when data returns
   logic        start;
   logic        fin;
   logic        allow;
   logic        wr;
   logic [15:0] addr;
   logic [15:0] wdat;
   always_comb begin
      allow = 1'b0;
      wr    = 1'b0;
      addr  = ba_q;
      wdat  = opnd_q;
      unique case (st_q)
         S_IDX:   begin
            allow = 1'b1;
            addr  = opnd_q + gpr_q[ir_q[2:0]];
         end
         S_WB2:   begin
            allow = is_byte;
            wr    = 1'b1;
         end
         S_PSHS:  begin
            wr    = 1'b1;
            addr  = gpr_q[SP_IDX] - STEP2;
            wdat  = psw_q;
         end
         S_PSHP:  begin
            wr    = 1'b1;
            addr  = gpr_q[SP_IDX] - STEP2;
            wdat  = gpr_q[PC_IDX];
         end
         S_VPC:   addr = opnd_q;
         S_VPSW:  addr = opnd_q + STEP2;
         default: ;
      endcase
   end
   logic bus_st;
   assign bus_st = st_q inside {S_IDX, S_WB2, S_PSHS, S_PSHP, S_VPC, S_VPSW};
   // a new access waits until done from the last one has fallen
   assign start  = bus_st && !acc_q && !done_s;
   assign fin    = bus_st && acc_q && done_s;
   logic berr;
   assign berr   = start && addr[0] && !allow;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_out        <= '0;
         acc_q          <= 1'b0;
         clock_inhibit  <= 1'b0;
         odd_byte_allow <= 1'b0;
      end else if (start && !berr) begin
         mem_out        <= '{req: 1'b1, write: wr, addr: addr, wdata: wdat};
         acc_q          <= 1'b1;
         clock_inhibit  <= 1'b1;
         odd_byte_allow <= allow;
      end else if (fin) begin
         mem_out        <= '0;
         acc_q          <= 1'b0;
         clock_inhibit  <= 1'b0;
         odd_byte_allow <= 1'b0;
      end
   end

   // ==========================================
   // microstep sequencing
   logic [16:0] res;
   assign res = alu(ir_q[14:12], scr10_q, opnd_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= S_IDLE;
         win_q     <= W_NEXT;
         ba_q      <= WORD_RST;
         opnd_q    <= WORD_RST;
         scr11_q   <= WORD_RST;
         scr12_q   <= WORD_RST;
         psw_q     <= WORD_RST;
         bus_grant <= 4'h0;
         halted    <= 1'b0;
      end else if (berr) begin
         st_q      <= S_BERR;
      end else begin
         if (apb_wr && st_q inside {S_IDLE, S_FTCH, S_HALT}) begin
            if (paddr == OFF_OPND) opnd_q <= pwdata[15:0];
            if (paddr == OFF_PSW) psw_q <= pwdata[15:0];
            if (paddr == OFF_CTRL && pwdata[CTRL_START]) begin
               st_q   <= S_IDX;
               halted <= 1'b0;
            end
         end
         unique case (st_q)
            S_IDX: if (fin) begin
               ba_q   <= mem_out.addr;
               opnd_q <= rdata_s;
               st_q   <= (is_jmp || is_jsr) ? S_JMP : S_DRX;
            end
            S_JMP:  st_q <= S_SVC;
            S_DRX:  st_q <= (is_byte && ba_q[0]) ? S_BYTE : S_STOR;
            S_BYTE: begin
               opnd_q <= {8'h00, opnd_q[15:8]};
               st_q   <= S_STOR;
            end
            S_STOR: begin
               scr11_q <= opnd_q;
               st_q    <= is_unary ? S_UNRY : S_ALU;
            end
            S_UNRY, S_ALU: begin
               if (st_q == S_ALU) opnd_q <= res[15:0];
               else if (ir_q[8:6] == 3'h0) opnd_q <= WORD_RST;
               else if (ir_q[8:6] == 3'h1) opnd_q <= ~opnd_q;
               psw_q[3:0] <= {res[15], res[15:0] == 16'h0000, 1'b0, res[16]};
               st_q       <= no_write ? S_SVC : S_WB1;
            end
            S_WB1:  st_q <= S_WB2;
            S_WB2:  if (fin) st_q <= S_SVC;
            S_SVC:  begin
               win_q <= win;
               if (win inside {W_BR7, W_BR6, W_BR5, W_BR4}) begin
                  st_q      <= S_BG;
                  bus_grant <= win == W_BR7 ? 4'h8 : win == W_BR6 ? 4'h4
                               : win == W_BR5 ? 4'h2 : 4'h1;
               end else if (win == W_STOP) begin
                  st_q   <= S_HALT;
                  halted <= 1'b1;
               end else if (win == W_NEXT) begin
                  st_q <= S_FTCH;
               end else begin
                  st_q <= S_TRAP;
               end
            end
            S_BG:   if (intr_s) begin
               st_q <= S_INT;
            end else if ((bus_grant & br_s) == 4'h0) begin
               bus_grant <= 4'h0;
               st_q      <= S_SVC;
            end
            S_INT:  begin
               scr12_q   <= bdata_s;
               opnd_q    <= bdata_s;
               bus_grant <= 4'h0;
               st_q      <= S_PSHS;
            end
            S_TRAP: begin
               opnd_q <= vec_of(win_q);
               st_q   <= S_PSHS;
            end
            S_BERR: begin
               opnd_q <= VEC_BERR;
               st_q   <= S_PSHS;
            end
            S_PSHS: if (fin) st_q <= S_PSHP;
            S_PSHP: if (fin) st_q <= S_VPC;
            S_VPC:  if (fin) st_q <= S_VPSW;
            S_VPSW: if (fin) begin
               psw_q <= rdata_s;
               st_q  <= S_SVC;
            end
            default: ;
         endcase
      end
   end

   // ==========================================
   // register file, scratch 10 and instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) gpr_q[i] <= WORD_RST;
         ir_q    <= WORD_RST;
         scr10_q <= WORD_RST;
      end else begin
         if (apb_wr && st_q inside {S_IDLE, S_FTCH, S_HALT}) begin
            if (paddr[7:5] == 3'h1) gpr_q[paddr[4:2]] <= pwdata[15:0];
            if (paddr == OFF_IR) ir_q <= pwdata[15:0];
            if (paddr == OFF_SCR10) scr10_q <= pwdata[15:0];
         end
         if (start && !berr && st_q inside {S_PSHS, S_PSHP}) begin
            gpr_q[SP_IDX] <= gpr_q[SP_IDX] - STEP2;
         end
         if (fin && st_q == S_VPC) gpr_q[PC_IDX] <= rdata_s;
      end
   end

   // ==========================================
   // interrupt status, mask and line
   assign ev_set = {st_q == S_TRAP, st_q == S_INT, berr,
                    st_q == S_SVC && win inside {W_NEXT, W_STOP}};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= MASK_RST;
         imask_q <= MASK_RST;
         irq     <= 1'b0;
      end else begin
         istat_q <= ((apb_rd && paddr == OFF_INT_STAT) ? (istat_q & ~prdata[3:0]) : istat_q)
                    | ev_set;
         if (apb_wr && paddr == OFF_INT_MASK) imask_q <= pwdata[3:0];
         irq <= |(istat_q & imask_q);
      end
   end

   // ==========================================
   // APB slave, one wait-free access phase
   logic        hit;
   logic [31:0] rd;
   always_comb begin
      hit = 1'b1;
      rd  = 32'h0000_0000;
      if (paddr[7:5] == 3'h1 && paddr[1:0] == 2'h0) begin
         rd = {16'h0000, gpr_q[paddr[4:2]]};
      end else begin
         unique case (paddr)
            OFF_CTRL:     rd = 32'h0000_0000;
            OFF_IR:       rd = {16'h0000, ir_q};
            OFF_OPND:     rd = {16'h0000, opnd_q};
            OFF_SCR10:    rd = {16'h0000, scr10_q};
            OFF_PSW:      rd = {16'h0000, psw_q};
            OFF_STATUS:   rd = {19'h0, halted, win_q, 3'h0, st_q};
            OFF_INT_STAT: rd = {28'h0, istat_q};
            OFF_INT_MASK: rd = {28'h0, imask_q};
            OFF_SCR11:    rd = {16'h0000, scr11_q};
            OFF_SCR12:    rd = {16'h0000, scr12_q};
            default:      hit = 1'b0;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pready  <= 1'b1;
         prdata  <= rd;
         pslverr <= !hit;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ==========================================
   // checks
   a_index_addr: assert property (@(posedge pclk) disable iff (!presetn)
      start && st_q == S_IDX && !berr |=> mem_out.addr == opnd_q + gpr_q[ir_q[2:0]])
      else $error("indexed address wrong");
   a_odd_allow: assert property (@(posedge pclk) disable iff (!presetn)
      start && st_q == S_IDX |-> !berr)
      else $error("odd byte read refused");
   a_jump_branch: assert property (@(posedge pclk) disable iff (!presetn)
      fin && st_q == S_IDX && !is_jmp && !is_jsr |=> st_q == S_DRX)
      else $error("jump test misrouted");
   a_inhibit_hold: assert property (@(posedge pclk) disable iff (!presetn)
      clock_inhibit && !done_s |=> $stable(st_q))
      else $error("step moved during inhibit");
   a_byte_move: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == S_BYTE |=> opnd_q == {8'h00, $past(opnd_q[15:8])} && st_q == S_STOR)
      else $error("byte not moved low");
   a_unary_split: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == S_STOR |=> scr11_q == $past(opnd_q) && (st_q == S_UNRY) == $past(is_unary))
      else $error("single operand test wrong");
   sequence wb_path;
      st_q == S_WB1 ##1 st_q == S_WB2;
   endsequence
   a_write_back: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == S_ALU && !no_write |=> wb_path)
      else $error("write back skipped");
   a_one_winner: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == S_SVC && psw_q[PSW_TRACE] |=> win_q == W_TRACE && st_q == S_TRAP)
      else $error("trace not highest");
   a_fetch_next: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == S_SVC && pend == 12'h000 |=> st_q == S_FTCH)
      else $error("idle service not fetched");
   a_vector_load: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == S_INT |=> scr12_q == $past(bdata_s) && st_q == S_PSHS)
      else $error("vector not taken");
   a_berr_entry: assert property (@(posedge pclk) disable iff (!presetn)
      berr |=> st_q == S_BERR ##1 opnd_q == VEC_BERR)
      else $error("bus error not forced");
endmodule : tail_seq
`default_nettype wire

// *** tail_seq_pkg.sv ***
// package: constants, arbitration winners and carriers of the service and trap sequencer
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package tail_seq_pkg;
   // ==========================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_IR       = 8'h04;
   localparam logic [7:0] OFF_OPND     = 8'h08;
   localparam logic [7:0] OFF_SCR10    = 8'h10;
   localparam logic [7:0] OFF_PSW      = 8'h14;
   localparam logic [7:0] OFF_STATUS   = 8'h18;
   localparam logic [7:0] OFF_INT_STAT = 8'h1C;
   localparam logic [7:0] OFF_GPR      = 8'h20;
   localparam logic [7:0] OFF_INT_MASK = 8'h40;
   localparam logic [7:0] OFF_SCR11    = 8'h44;
   localparam logic [7:0] OFF_SCR12    = 8'h48;
   // ==========================================
   // field positions and reset values
   localparam int         CTRL_START   = 0;
   localparam int         PSW_TRACE    = 4;
   localparam int         EV_DONE      = 0;
   localparam int         EV_BERR      = 1;
   localparam int         EV_INT       = 2;
   localparam int         EV_TRAP      = 3;
   localparam logic [3:0] MASK_RST     = 4'h0;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [15:0] STEP2       = 16'h0002;
   localparam int         SP_IDX       = 6;
   localparam int         PC_IDX       = 7;
   // ==========================================
   // fixed trap vectors (plain defaults)
   localparam logic [15:0] VEC_TRACE   = 16'h0010;
   localparam logic [15:0] VEC_STACK   = 16'h0020;
   localparam logic [15:0] VEC_POWER   = 16'h0030;
   localparam logic [15:0] VEC_LCLK    = 16'h0040;
   localparam logic [15:0] VEC_URX     = 16'h0050;
   localparam logic [15:0] VEC_UTX     = 16'h0060;
   localparam logic [15:0] VEC_BERR    = 16'h0070;
   // ==========================================
   // service arbitration winners, highest first
   typedef enum logic [3:0] {
      W_TRACE = 4'h0, W_STACK = 4'h1, W_POWER = 4'h2, W_BR7 = 4'h3,
      W_BR6   = 4'h4, W_LCLK  = 4'h5, W_BR5   = 4'h6, W_BR4 = 4'h7,
      W_URX   = 4'h8, W_UTX   = 4'h9, W_STOP  = 4'hA, W_NEXT = 4'hB
   } winner_t;
   // ==========================================
   // memory bus request carrier
   typedef struct packed {
      logic        req;
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_t;
endpackage : tail_seq_pkg
`default_nettype wire
